// File: ulpi_rx_command_status_tb.sv
/*
 * Self-checking bench for the ULPI status-byte scheduler and encoder.
 * Assumes urc_pkg, the design and urc_link_model are compiled first.
 */
module ulpi_rx_command_status_tb
    import urc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 0, ulpi_clk = 0, rst_n = 0, dir_q = 0;
    logic hs = 0, asy = 0, alt = 0, stp_req = 0, busy = 0, tx = 0;
    logic rx_act = 0, rx_err = 0, hdis = 0, rxv = 0;
    logic [7:0] rxb = 8'h00;
    urc_comp_s comp = URC_RST_COMP;
    logic dir, nxt, oe, stp;
    logic [7:0] dout, din, last;
    logic [15:0] cnt;
    logic [31:0] seed = 32'h0001098F;
    int err_count = 0, num_checks = 0, cycles = 0;
    logic [6:0] corner [4] = '{7'h48, 7'h20, 7'h05, 7'h63};
    logic [1:0] rxf [3] = '{URC_RX_ACT, URC_RX_ERR, URC_RX_HDIS};

    always #20 clk = ~clk;
    always #15 ulpi_clk = ~ulpi_clk;

    urc_rx_command_status DUT (
        .clk_in(clk), .rst_n_in(rst_n), .comp_in(comp), .hs_mode_in(hs),
        .async_mode_in(asy), .alt_int_in(alt), .ulpi_clk_in(ulpi_clk), .stp_in(stp),
        .data_in(din), .dir_out(dir), .nxt_out(nxt), .data_out(dout), .data_oe_out(oe),
        .rx_active_in(rx_act), .rx_error_in(rx_err), .host_disc_in(hdis),
        .rx_byte_valid_in(rxv), .rx_byte_in(rxb), .tx_active_in(tx));

    urc_link_model LINK (
        .ulpi_clk_in(ulpi_clk), .rst_n_in(rst_n), .stp_req_in(stp_req), .busy_in(busy),
        .dir_in(dir), .nxt_in(nxt), .oe_in(oe), .phy_data_in(dout), .stp_out(stp),
        .data_out(din), .last_out(last), .count_out(cnt));

    // ==========================================================================
    // Helpers
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] exp_byte(urc_comp_s c, logic h, logic a, logic [1:0] r);
        logic [1:0] ls, vb;
        ls = h ? (c.squelch ? URC_LS_HS_SQ : URC_LS_HS_ACT) : {c.dm, c.dp};
        vb = c.vbus_vld ? URC_VBUS_VLD : c.sess_vld ? URC_VBUS_SVLD : c.sess_end ? URC_VBUS_LOW : URC_VBUS_SESS;
        return {a, c.id, r, vb, ls};
    endfunction

    // Waits until no byte has moved for 40 cycles; sync latency is well inside that
    task automatic quiet();
        logic [15:0] c0;
        int idle;
        idle = 0;
        for (int i = 0; i < 1000 && idle < 40; i++) begin
            c0 = cnt;
            @(posedge ulpi_clk);
            idle = (cnt == c0 && !dir) ? idle + 1 : 0;
        end
    endtask

    // ==========================================================================
    // Bus watch and timeout
    always @(posedge ulpi_clk) begin
        dir_q <= dir;
        if (rst_n && dir && !dir_q) check("turnaround_oe", {7'h0, oe}, 8'h00);
        if (rst_n && oe) check("oe_with_dir", {7'h0, dir}, 8'h01);
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            complete_run();
        end
    end

    // ==========================================================================
    // Main sequence
    initial begin
        logic [15:0] c0;
        logic [7:0] e, ep;
        urc_comp_s cv;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        quiet();
        check("startup_sent", {7'h0, cnt != 0}, 8'h01);
        check("startup_value", last, exp_byte(comp, hs, alt, URC_RX_IDLE));
        ep = last;
        // Corner comparator sets first, then random ones
        for (int i = 0; i < 28; i++) begin
            seed = xs(seed);
            cv = urc_comp_s'((i < 4) ? corner[i] : seed[6:0]);
            c0 = cnt;
            @(posedge clk);
            comp <= cv;
            hs <= seed[8];
            alt <= seed[9];
            e = exp_byte(cv, seed[8], seed[9], URC_RX_IDLE);
            quiet();
            check("status_value", last, e);
            if (e !== ep) check("status_sent", {7'h0, cnt != c0}, 8'h01);
            ep = e;
        end
        // Blocked cases: async mode, busy link, high-speed and full-speed transmit
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            asy <= (m == 0);
            hs <= (m == 2);
            @(posedge ulpi_clk);
            busy <= (m == 1);
            tx <= (m >= 2);
            quiet();
            c0 = cnt;
            @(posedge clk);
            comp.id <= ~comp.id;
            quiet();
            check("blocked", cnt[7:0], c0[7:0]);
            if (m >= 2) begin
                @(posedge ulpi_clk);
                stp_req <= 1'b1;
                // Full speed may answer while STP is still high; high speed must not
                repeat (4) @(posedge ulpi_clk);
                check("blocked_stp_high", {7'h0, cnt != c0}, {7'h0, m == 3});
                stp_req <= 1'b0;
                repeat (2) @(posedge ulpi_clk);
                tx <= 1'b0;
            end
            @(posedge clk);
            asy <= 1'b0;
            @(posedge ulpi_clk);
            busy <= 1'b0;
            quiet();
            check("released", {7'h0, cnt != c0}, 8'h01);
            check("released_value", last, exp_byte(comp, hs, alt, URC_RX_IDLE));
        end
        // Receive with plain, errored and disconnect events
        for (int k = 0; k < 3; k++) begin
            c0 = cnt;
            @(posedge ulpi_clk);
            rx_act <= 1'b1;
            rx_err <= (k == 1);
            hdis <= (k == 2);
            for (int j = 0; j < 30; j++) begin
                @(posedge ulpi_clk);
                if (dir && oe && !nxt && j > 8) check("rx_field", {6'h0, dout[5:4]}, {6'h0, rxf[k]});
                seed = xs(seed);
                rxv <= seed[0];
                rxb <= seed[15:8];
            end
            check("rx_status_sent", {7'h0, cnt != c0}, 8'h01);
            rx_act <= 1'b0;
            rx_err <= 1'b0;
            hdis <= 1'b0;
            rxv <= 1'b0;
            quiet();
            check("rx_end_value", last, exp_byte(comp, hs, alt, URC_RX_IDLE));
        end
        complete_run();
    end
endmodule // ulpi_rx_command_status_tb

// File: urc_link_model.sv
/*
 * Link-side model of the ULPI bus for the status-byte bench.
 * Assumes the PHY drives data only while dir is high and that the bench
 * asks for stp and for non-idle link traffic through plain request inputs.
 */
module urc_link_model
    import urc_pkg::*;
(
    // ULPI clock and reset
    input  wire logic        ulpi_clk_in,
    input  wire logic        rst_n_in,
    // Requests from the bench
    input  wire logic        stp_req_in,
    input  wire logic        busy_in,
    // PHY side of the bus
    input  wire logic        dir_in,
    input  wire logic        nxt_in,
    input  wire logic        oe_in,
    input  wire logic [7:0]  phy_data_in,
    output logic             stp_out,
    output logic [7:0]       data_out,
    // Captured status bytes
    output logic [7:0]       last_out,
    output logic [15:0]      count_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] pat;

    // ==========================================================================
    // Bus drive
    // A released bus toggles every cycle so a stale value never reads as idle
    always_ff @(posedge ulpi_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pat <= 8'h5A;
        end else begin
            pat <= ~pat;
        end
    end
    assign data_out = dir_in ? pat : (busy_in ? 8'h41 : URC_ULPI_IDLE);
    assign stp_out  = stp_req_in;

    // ==========================================================================
    // Status byte capture: dir high with nxt low marks a status byte
    always_ff @(posedge ulpi_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_out  <= 8'h00;
            count_out <= 16'h0000;
        end else if (dir_in && oe_in && !nxt_in) begin
            last_out  <= phy_data_in;
            count_out <= count_out + 16'h0001;
        end
    end
endmodule // urc_link_model

// File: urc_pkg.sv
/*
 * Shared constants, carriers and states for the ULPI receive-command status block.
 * Assumes the includer imports urc_pkg::* and that both clock domains reset from one pin.
 */
package urc_pkg;

    // ==========================================================================
    // Field positions inside the receive-command byte
    localparam int unsigned URC_POS_LS   = 0;
    localparam int unsigned URC_POS_VBUS = 2;
    localparam int unsigned URC_POS_RXEV = 4;
    localparam int unsigned URC_POS_ID   = 6;
    localparam int unsigned URC_POS_ALT  = 7;

    // ==========================================================================
    // Field encodings
    localparam logic [1:0] URC_VBUS_LOW  = 2'h0;
    localparam logic [1:0] URC_VBUS_SESS = 2'h1;
    localparam logic [1:0] URC_VBUS_SVLD = 2'h2;
    localparam logic [1:0] URC_VBUS_VLD  = 2'h3;
    localparam logic [1:0] URC_RX_IDLE   = 2'h0;
    localparam logic [1:0] URC_RX_ACT    = 2'h1;
    localparam logic [1:0] URC_RX_ERR    = 2'h3;
    localparam logic [1:0] URC_RX_HDIS   = 2'h2;
    localparam logic [1:0] URC_LS_HS_SQ  = 2'h0;
    localparam logic [1:0] URC_LS_HS_ACT = 2'h1;

    // ==========================================================================
    // Bus values and values after reset
    localparam logic [7:0] URC_ULPI_IDLE  = 8'h00;
    localparam logic [7:0] URC_RST_DATA   = 8'h00;
    localparam logic       URC_RST_HELLO  = 1'b1;
    localparam logic       URC_RST_LEVEL  = 1'b0;

    // ==========================================================================
    // Carriers
    typedef struct packed {
        logic dp;
        logic dm;
        logic squelch;
        logic sess_end;
        logic sess_vld;
        logic vbus_vld;
        logic id;
    } urc_comp_s;

    typedef struct packed {
        logic       alt_int;
        logic       id;
        logic [1:0] vbus;
        logic [1:0] ls;
    } urc_status_s;

    localparam urc_comp_s   URC_RST_COMP   = '0;
    localparam urc_status_s URC_RST_STATUS = '0;

    typedef enum logic [2:0] {
        URC_IDLE,
        URC_TURN,
        URC_CMD,
        URC_RX,
        URC_BACK
    } urc_state_e;

endpackage : urc_pkg

// File: urc_rx_command_status.sv
/*
 * ULPI receive-command scheduler and encoder, PHY side.
 * Assumes comparator pins are asynchronous, core controls run on clk_in,
 * and stp/data/receiver/transmitter signals run on the ULPI clock.
 */
// Functional notes
// - Status byte may be sent whenever bus idle
// - Every transfer begins by raising DIR
// - Back-to-back status bytes when more updates arrive
// - Only in synchronous mode while owning bus
// - Line state change schedules a status byte
// - VBUS or ID comparator change schedules byte
// - During receive, status byte whenever NXT low
// - Start-up: send byte once DIR, STP low
// - Exiting asynchronous modes: send byte after STP low
// - During transmit, send only after STP asserted
// - High-speed transmit: hold until STP deasserts
// - Byte carries status current when driven
// - Bits 1:0 carry line state
// - Bits 3:2 carry encoded VBUS level
// - Bits 5:4 carry encoded receive events
// - Bit 6 carries ID pin level
// - Bit 7 flags pending non-USB interrupt
// - Full/low speed line state from single-ended receivers
// - High speed line state reports squelch only
module urc_rx_command_status
    import urc_pkg::*;
(
    // System clock domain
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Analog comparator outputs, asynchronous
    input  wire urc_comp_s  comp_in,
    // Core controls on clk_in
    input  wire logic       hs_mode_in,
    input  wire logic       async_mode_in,
    input  wire logic       alt_int_in,
    // ULPI link side
    input  wire logic       ulpi_clk_in,
    input  wire logic       stp_in,
    input  wire logic [7:0] data_in,
    output logic            dir_out,
    output logic            nxt_out,
    output logic [7:0]      data_out,
    output logic            data_oe_out,
    // Receiver and transmitter on the ULPI clock
    input  wire logic       rx_active_in,
    input  wire logic       rx_error_in,
    input  wire logic       host_disc_in,
    input  wire logic       rx_byte_valid_in,
    input  wire logic [7:0] rx_byte_in,
    input  wire logic       tx_active_in
);

    // ==========================================================================
    // Encoders
    function automatic logic [1:0] enc_vbus(input urc_comp_s c);
        if (c.vbus_vld) begin
            return URC_VBUS_VLD;
        end else if (c.sess_vld) begin
            return URC_VBUS_SVLD;
        end else if (c.sess_end) begin
            return URC_VBUS_LOW;
        end
        return URC_VBUS_SESS;
    endfunction

    function automatic logic [1:0] enc_rxev(input logic act, input logic err, input logic hdis);
        if (hdis) begin
            return URC_RX_HDIS;
        end else if (act) begin
            return err ? URC_RX_ERR : URC_RX_ACT;
        end
        return URC_RX_IDLE;
    endfunction

    // ==========================================================================
    // System domain: comparator capture and change events
    urc_comp_s   comp_m;
    urc_comp_s   comp_s;
    urc_status_s status_c;
    urc_status_s next_status;
    logic        ev_tgl;
    logic        async_c;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            comp_m <= URC_RST_COMP;
            comp_s <= URC_RST_COMP;
        end else begin
            comp_m <= comp_in;
            comp_s <= comp_m;
        end
    end

    always_comb begin
        next_status.alt_int = alt_int_in;
        next_status.id      = comp_s.id;
        next_status.vbus    = enc_vbus(comp_s);
        // High speed reuses the field as an activity flag
        next_status.ls      = hs_mode_in ? (comp_s.squelch ? URC_LS_HS_SQ : URC_LS_HS_ACT)
                                         : {comp_s.dm, comp_s.dp};
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_c <= URC_RST_STATUS;
            ev_tgl   <= URC_RST_LEVEL;
            async_c  <= URC_RST_LEVEL;
        end else begin
            status_c <= next_status;
            async_c  <= async_mode_in;
            // A toggle survives a stopped ULPI clock, so no event is lost in async modes
            if (next_status != status_c) begin
                ev_tgl <= ~ev_tgl;
            end
        end
    end

    // ==========================================================================
    // ULPI domain: reset release and crossings
    logic        ursync_m;
    logic        ulpi_rst_n;
    urc_status_s st_m;
    urc_status_s st_u;
    logic        ev_m;
    logic        ev_s;
    logic        ev_d;
    logic        as_m;
    logic        as_u;
    logic        as_d;
    logic        hs_m;
    logic        hs_u;
    logic        hs_c;

    always_ff @(posedge ulpi_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ursync_m   <= URC_RST_LEVEL;
            ulpi_rst_n <= URC_RST_LEVEL;
        end else begin
            ursync_m   <= 1'b1;
            ulpi_rst_n <= ursync_m;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hs_c <= URC_RST_LEVEL;
        end else begin
            hs_c <= hs_mode_in;
        end
    end

    always_ff @(posedge ulpi_clk_in or negedge ulpi_rst_n) begin
        if (!ulpi_rst_n) begin
            st_m <= URC_RST_STATUS;
            st_u <= URC_RST_STATUS;
            ev_m <= URC_RST_LEVEL;
            ev_s <= URC_RST_LEVEL;
            ev_d <= URC_RST_LEVEL;
            as_m <= URC_RST_LEVEL;
            as_u <= URC_RST_LEVEL;
            as_d <= URC_RST_LEVEL;
            hs_m <= URC_RST_LEVEL;
            hs_u <= URC_RST_LEVEL;
        end else begin
            st_m <= status_c;
            st_u <= st_m;
            ev_m <= ev_tgl;
            ev_s <= ev_m;
            ev_d <= ev_s;
            as_m <= async_c;
            as_u <= as_m;
            as_d <= as_u;
            hs_m <= hs_c;
            hs_u <= hs_m;
        end
    end

    // ==========================================================================
    // ULPI domain: scheduling
    urc_state_e state;
    urc_state_e next_state;
    logic       hello;
    logic       pending;
    logic       stp_seen;
    logic [1:0] rxev_d;
    logic [1:0] rxev;
    logic       hello_go;
    logic       new_ev;
    logic       tx_ok;
    logic       can_start;
    logic       drive_cmd;

    assign rxev     = enc_rxev(rx_active_in, rx_error_in, host_disc_in);
    assign hello_go = hello && !as_u && !dir_out && !stp_in;
    assign new_ev   = (ev_s ^ ev_d) || (rxev != rxev_d) || hello_go;
    // Full speed may answer in the STP cycle; high speed waits for STP to fall
    assign tx_ok    = !tx_active_in || (hs_u ? (stp_seen && !stp_in)
                                             : (stp_seen || stp_in));
    assign can_start = (state == URC_IDLE) && !as_u && tx_ok
                    && (tx_active_in || data_in == URC_ULPI_IDLE);
    assign drive_cmd = (next_state == URC_CMD)
                    || (next_state == URC_RX && !rx_byte_valid_in);

    always_ff @(posedge ulpi_clk_in or negedge ulpi_rst_n) begin
        if (!ulpi_rst_n) begin
            hello <= URC_RST_HELLO;
        end else if (as_d && !as_u) begin
            hello <= 1'b1;
        end else if (hello_go) begin
            hello <= 1'b0;
        end
    end

    always_ff @(posedge ulpi_clk_in or negedge ulpi_rst_n) begin
        if (!ulpi_rst_n) begin
            pending <= URC_RST_LEVEL;
            rxev_d  <= URC_RX_IDLE;
        end else begin
            rxev_d  <= rxev;
            // A new event in the sending cycle keeps the flag set
            pending <= new_ev || (pending && !drive_cmd);
        end
    end

    always_ff @(posedge ulpi_clk_in or negedge ulpi_rst_n) begin
        if (!ulpi_rst_n) begin
            stp_seen <= URC_RST_LEVEL;
        end else if (!tx_active_in) begin
            stp_seen <= 1'b0;
        end else if (stp_in) begin
            stp_seen <= 1'b1;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            URC_IDLE: begin
                if (!as_u && rx_active_in) begin
                    next_state = URC_TURN;
                end else if (can_start && pending) begin
                    next_state = URC_TURN;
                end
            end
            URC_TURN: begin
                next_state = rx_active_in ? URC_RX : URC_CMD;
            end
            URC_CMD: begin
                if (rx_active_in) begin
                    next_state = URC_RX;
                end else if (!new_ev) begin
                    next_state = URC_BACK;
                end
            end
            URC_RX: begin
                if (!rx_active_in) begin
                    next_state = URC_CMD;
                end
            end
            URC_BACK: begin
                next_state = URC_IDLE;
            end
            default: begin
                next_state = URC_IDLE;
            end
        endcase
    end

    always_ff @(posedge ulpi_clk_in or negedge ulpi_rst_n) begin
        if (!ulpi_rst_n) begin
            state <= URC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================================
    // ULPI domain: bus drive, byte assembled from live status
    always_ff @(posedge ulpi_clk_in or negedge ulpi_rst_n) begin
        if (!ulpi_rst_n) begin
            dir_out     <= URC_RST_LEVEL;
            nxt_out     <= URC_RST_LEVEL;
            data_oe_out <= URC_RST_LEVEL;
            data_out    <= URC_RST_DATA;
        end else begin
            dir_out     <= (next_state == URC_TURN) || (next_state == URC_CMD) || (next_state == URC_RX);
            data_oe_out <= (next_state == URC_CMD) || (next_state == URC_RX);
            nxt_out     <= (next_state == URC_TURN && rx_active_in)
                        || (next_state == URC_RX && rx_byte_valid_in);
            if (drive_cmd) begin
                data_out[URC_POS_LS +: 2]   <= st_u.ls;
                data_out[URC_POS_VBUS +: 2] <= st_u.vbus;
                data_out[URC_POS_RXEV +: 2] <= rxev;
                data_out[URC_POS_ID]        <= st_u.id;
                data_out[URC_POS_ALT]       <= st_u.alt_int;
            end else if (next_state == URC_RX) begin
                data_out <= rx_byte_in;
            end else begin
                data_out <= URC_RST_DATA;
            end
        end
    end

    // ==========================================================================
    // Assertions
    property p_turn_quiet;
        @(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        $rose(dir_out) |-> !data_oe_out ##1 (data_oe_out || !dir_out);
    endproperty
    a_turn_quiet: assert property (p_turn_quiet) else $error("data driven in turnaround");

    property p_dir_first;
        @(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        data_oe_out |-> dir_out && $past(dir_out);
    endproperty
    a_dir_first: assert property (p_dir_first) else $error("bus driven without owning DIR");

    property p_pending_served;
        @(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        (pending && can_start && !rx_active_in) |=> dir_out ##1 (data_oe_out && !nxt_out);
    endproperty
    a_pending_served: assert property (p_pending_served) else $error("pending status not sent");

    property p_rx_cmd_on_nxt_low;
        @(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        (state == URC_RX && !nxt_out) |-> data_oe_out && data_out[URC_POS_RXEV +: 2] != URC_RX_IDLE;
    endproperty
    a_rx_cmd_on_nxt_low: assert property (p_rx_cmd_on_nxt_low) else $error("no status byte in receive");

    property p_tx_wait_stp;
        @(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        (tx_active_in && !stp_seen && !stp_in && !rx_active_in) |=> !$rose(dir_out);
    endproperty
    a_tx_wait_stp: assert property (p_tx_wait_stp) else $error("status sent before STP in transmit");

    property p_hs_block;
        @(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        (tx_active_in && hs_u && stp_in && !rx_active_in && state == URC_IDLE) |=> !dir_out;
    endproperty
    a_hs_block: assert property (p_hs_block) else $error("status sent while STP high in HS transmit");

    property p_async_silent;
        @(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        (as_u && state == URC_IDLE) |=> !dir_out;
    endproperty
    a_async_silent: assert property (p_async_silent) else $error("bus taken in async mode");

    property p_hdis_code;
        @(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        (data_oe_out && !nxt_out) |-> ((data_out[URC_POS_RXEV +: 2] == URC_RX_HDIS) == $past(host_disc_in));
    endproperty
    a_hdis_code: assert property (p_hdis_code) else $error("receive event field wrong");

    property p_hs_linestate;
        @(posedge clk_in) disable iff (!rst_n_in)
        hs_mode_in |=> status_c.ls[1] == 1'b0 && status_c.ls[0] == !$past(comp_s.squelch);
    endproperty
    a_hs_linestate: assert property (p_hs_linestate) else $error("HS line state wrong");

    property p_vbus_valid;
        @(posedge clk_in) disable iff (!rst_n_in)
        comp_s.vbus_vld |=> status_c.vbus == URC_VBUS_VLD;
    endproperty
    a_vbus_valid: assert property (p_vbus_valid) else $error("VBUS code wrong");

    property p_change_event;
        @(posedge clk_in) disable iff (!rst_n_in)
        (next_status != status_c) |=> ev_tgl != $past(ev_tgl);
    endproperty
    a_change_event: assert property (p_change_event) else $error("status change not signalled");

    c_single_cmd: cover property (@(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        state == URC_TURN ##1 state == URC_CMD ##1 state == URC_BACK);
    c_back_to_back: cover property (@(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        state == URC_CMD ##1 state == URC_CMD);
    c_rx_packet: cover property (@(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        state == URC_RX && nxt_out ##1 state == URC_RX && !nxt_out);
    c_async_exit: cover property (@(posedge ulpi_clk_in) disable iff (!ulpi_rst_n)
        hello_go && as_d == 1'b0);

endmodule // urc_rx_command_status
